//--- core/cras_core.sv
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "cras_map.svh"
// Contract
// - L1 data tag: 34 bits, 7 check bits; correctable error evicts, corrects, refills.
// - L1 data word: 32 data plus poison bit, 7 check bits.
// - Translation entry 71 bits, two interleaved parity; error invalidates and rewalks.
// - L2 tag 7 check bits over 35 or 34 bits by size; corrected inline.
// - L2 and queue data: 8 check bits per 64 bits, corrected inline.
// - Corrected data goes straight to requester with no second access.
// - Any error triggers correction; two-bit errors are uncorrectable.
// - Uncorrectable data error poisons the chunk; poison travels and is stored.
// - One poison bit per 64 data bits, per 32 in L1 data.
// - Uncorrectable tag error invalidates line and raises recovery interrupt.
// - Any single-bit ECC error is reported as corrected.
// - Double-bit error in L1 or L2 data RAM reports deferred.
// - Double-bit error in L1 or L2 tag RAM reports uncorrected.
// - External aborts on stores, maintenance, invalidation, copyback report uncorrected.
// - Barrier waits only for accesses able to give asynchronous aborts.
// - Barrier imposes no ordering and no pipeline flush.
// - Earlier system errors have pended an interrupt before barrier completes.
// - Unmasked pending physical interrupt is taken before barrier completes.
// - Masked physical interrupt is cleared, status recorded, abort flag set.
// - Unmasked pending virtual interrupt is taken before barrier completes.
// - Masked virtual interrupt cleared, status recorded from virtual syndrome.
// - Deferred status needs level 1; routed non-secure level 1 reaches virtual.
// - Interleaved parity: one bit over even bits, one over odd.
module cras_core #(
  parameter int       L2_KB       = 256,
  parameter bit       EL2_PRESENT = 1'b1
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  // RAM write side
  input  wire logic                      wr_valid,
  input  wire cras_pkg::cras_ram_t       wr_ram,
  input  wire logic [70:0]               wr_data,
  input  wire logic                      wr_poison,
  output logic                           ram_wr_en_q,
  output cras_pkg::cras_ram_t            ram_wr_ram_q,
  output logic [`CRAS_WORD_W-1:0]        ram_wr_word_q,
  // RAM read side
  input  wire logic                      rd_valid,
  input  wire cras_pkg::cras_ram_t       rd_ram,
  input  wire logic [`CRAS_WORD_W-1:0]   rd_word,
  output logic                           rsp_valid_q,
  output logic [70:0]                    rsp_data_q,
  output logic                           rsp_poison_q,
  output logic                           rsp_ce_q,
  output logic                           rsp_de_q,
  output logic                           rsp_ue_q,
  output logic                           rsp_inval_q,
  output logic                           rsp_evict_refill_q,
  output logic                           rsp_walk_q,
  output logic                           err_recovery_irq_q,
  // External aborts
  input  wire logic                      ext_abort_valid,
  input  wire cras_pkg::cras_abort_t     ext_abort_kind,
  output logic                           abort_ue_q,
  // Error synchronization barrier
  input  wire logic                      esb_req,
  input  wire logic                      async_abort_outstanding,
  input  wire logic                      sys_err_in,
  input  wire logic [`CRAS_SYN_W-1:0]    sei_syndrome,
  input  wire logic                      vsei_set,
  input  wire logic                      phys_masked,
  input  wire logic                      virt_masked,
  output logic                           take_phys_q,
  output logic                           take_virt_q,
  output logic                           esb_done_q,
  output logic                           sei_pending_q,
  output logic                           vsei_pending_q,
  // Register port
  input  wire logic [3:0]                reg_addr,
  input  wire logic [31:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  input  wire logic [1:0]                reg_el,
  input  wire logic                      reg_ns,
  output logic [31:0]                    reg_rdata_q
);
  import cras_pkg::*;

  localparam int L2T_W = (L2_KB == 256) ? `CRAS_L2T_W256 : `CRAS_L2T_W512;

  // Hamming position of data bit i, skipping powers of two
  function automatic logic [6:0] dpos(input int i);
    logic [6:0] r;
    int         c;
    r = '0;
    c = 0;
    for (int p = 3; p < 128; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (c == i) begin
          r = 7'(p);
        end
        c++;
      end
    end
    return r;
  endfunction

  // Check bits; data must be zero above n
  function automatic logic [7:0] enc(input logic [63:0] d, input int n);
    logic [6:0] h;
    logic       op;
    h = '0;
    for (int i = 0; i < 64; i++) begin
      if (i < n && d[i]) begin
        h = h ^ dpos(i);
      end
    end
    op = (^d) ^ (^h);
    if (n > 57) begin
      return {op, h};
    end
    return {1'b0, op, h[5:0]};
  endfunction

  // Verify and correct a single flipped bit in place
  function automatic cras_dec_t dec(input logic [63:0] d, input logic [7:0] c, input int n);
    logic [7:0] e;
    logic [6:0] s;
    logic       po;
    cras_dec_t  r;
    e = enc(d, n);
    if (n > 57) begin
      s = e[6:0] ^ c[6:0];
    end else begin
      s = {1'b0, e[5:0] ^ c[5:0]};
    end
    po = (^d) ^ (^c);
    r.data = d;
    r.ce = po;
    r.ue = !po && (s != '0);
    for (int i = 0; i < 64; i++) begin
      if (po && i < n && dpos(i) == s) begin
        r.data[i] = ~d[i];
      end
    end
    return r;
  endfunction

  // Bit 0 covers even bits, bit 1 odd bits
  function automatic logic [1:0] par2(input logic [70:0] x);
    logic [1:0] p;
    p = '0;
    for (int i = 0; i < 71; i++) begin
      if (i % 2 == 0) begin
        p[0] = p[0] ^ x[i];
      end else begin
        p[1] = p[1] ^ x[i];
      end
    end
    return p;
  endfunction

  // Write side encoding
  logic [`CRAS_WORD_W-1:0] ww;
  logic [7:0]              we;
  logic [34:0]             wt;

  always_comb begin
    ww = '0;
    we = '0;
    wt = (L2_KB == 256) ? wr_data[34:0] : {1'b0, wr_data[33:0]};
    case (wr_ram)
      RAM_L1D_TAG: begin
        we = enc(64'(wr_data[33:0]), `CRAS_L1T_W);
        ww[33:0] = wr_data[33:0];
        ww[`CRAS_L1T_CHK+6:`CRAS_L1T_CHK] = we[6:0];
      end
      RAM_L1D_DATA: begin
        we = enc(64'({wr_poison, wr_data[31:0]}), `CRAS_L1D_W);
        ww[31:0] = wr_data[31:0];
        ww[`CRAS_L1D_POI] = wr_poison;
        ww[`CRAS_L1D_CHK+6:`CRAS_L1D_CHK] = we[6:0];
      end
      RAM_TLB: begin
        ww[70:0] = wr_data;
        ww[`CRAS_TLB_PAR+1:`CRAS_TLB_PAR] = par2(wr_data);
      end
      RAM_L2_TAG: begin
        we = enc(64'(wt), L2T_W);
        ww[34:0] = wt;
        ww[`CRAS_L2T_CHK+6:`CRAS_L2T_CHK] = we[6:0];
      end
      RAM_L2_DATA, RAM_TQ: begin
        we = enc(wr_data[63:0], `CRAS_L2D_W);
        ww[63:0] = wr_data[63:0];
        ww[`CRAS_L2D_CHK+7:`CRAS_L2D_CHK] = we;
        ww[`CRAS_L2D_POI] = wr_poison;
      end
      default: begin
        ww = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ram_wr_en_q <= 1'b0;
      ram_wr_ram_q <= RAM_L1D_TAG;
      ram_wr_word_q <= '0;
    end else begin
      ram_wr_en_q <= wr_valid;
      ram_wr_ram_q <= wr_ram;
      ram_wr_word_q <= wr_valid ? ww : '0;
    end
  end

  // Read side checking; one cycle from RAM word to response
  cras_dec_t   dr;
  logic [1:0]  pe;
  logic [34:0] rt;
  logic [70:0] d_data;
  logic        d_poi;
  logic        d_ce;
  logic        d_de;
  logic        d_ue;
  logic        d_inv;
  logic        d_evr;
  logic        d_walk;

  always_comb begin
    dr = '0;
    pe = '0;
    rt = (L2_KB == 256) ? rd_word[34:0] : {1'b0, rd_word[33:0]};
    d_data = '0;
    d_poi = 1'b0;
    d_ce = 1'b0;
    d_de = 1'b0;
    d_ue = 1'b0;
    d_inv = 1'b0;
    d_evr = 1'b0;
    d_walk = 1'b0;
    case (rd_ram)
      RAM_L1D_TAG: begin
        dr = dec(64'(rd_word[33:0]), 8'(rd_word[`CRAS_L1T_CHK+6:`CRAS_L1T_CHK]), `CRAS_L1T_W);
        d_data = 71'(dr.data[33:0]);
        d_ce = dr.ce;
        d_evr = dr.ce;
        d_ue = dr.ue;
        d_inv = dr.ue;
      end
      RAM_L1D_DATA: begin
        dr = dec(64'(rd_word[32:0]), 8'(rd_word[`CRAS_L1D_CHK+6:`CRAS_L1D_CHK]), `CRAS_L1D_W);
        d_data = 71'(dr.data[31:0]);
        d_poi = dr.data[`CRAS_L1D_POI] | dr.ue;
        d_ce = dr.ce;
        d_evr = dr.ce;
        d_de = dr.ue;
      end
      RAM_TLB: begin
        pe = par2(rd_word[70:0]) ^ rd_word[`CRAS_TLB_PAR+1:`CRAS_TLB_PAR];
        d_data = rd_word[70:0];
        d_inv = |pe;
        d_walk = |pe;
      end
      RAM_L2_TAG: begin
        dr = dec(64'(rt), 8'(rd_word[`CRAS_L2T_CHK+6:`CRAS_L2T_CHK]), L2T_W);
        d_data = 71'(dr.data[34:0]);
        d_ce = dr.ce;
        d_ue = dr.ue;
        d_inv = dr.ue;
      end
      RAM_L2_DATA, RAM_TQ: begin
        dr = dec(rd_word[63:0], rd_word[`CRAS_L2D_CHK+7:`CRAS_L2D_CHK], `CRAS_L2D_W);
        d_data = 71'(dr.data);
        d_poi = rd_word[`CRAS_L2D_POI] | dr.ue;
        d_ce = dr.ce;
        d_de = dr.ue && (rd_ram == RAM_L2_DATA);
      end
      default: begin
        d_data = '0;
      end
    endcase
  end

  // A two-bit error is never corrected, only flagged
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= '0;
      rsp_poison_q <= 1'b0;
      rsp_ce_q <= 1'b0;
      rsp_de_q <= 1'b0;
      rsp_ue_q <= 1'b0;
      rsp_inval_q <= 1'b0;
      rsp_evict_refill_q <= 1'b0;
      rsp_walk_q <= 1'b0;
      err_recovery_irq_q <= 1'b0;
    end else begin
      rsp_valid_q <= rd_valid;
      rsp_data_q <= rd_valid ? d_data : '0;
      rsp_poison_q <= rd_valid && d_poi;
      rsp_ce_q <= rd_valid && d_ce;
      rsp_de_q <= rd_valid && d_de;
      rsp_ue_q <= rd_valid && d_ue;
      rsp_inval_q <= rd_valid && d_inv;
      rsp_evict_refill_q <= rd_valid && d_evr;
      rsp_walk_q <= rd_valid && d_walk;
      err_recovery_irq_q <= rd_valid && d_ue;
    end
  end

  // External aborts; loads abort synchronously and are not reported here
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      abort_ue_q <= 1'b0;
    end else begin
      abort_ue_q <= ext_abort_valid && (ext_abort_kind != ABT_LOAD);
    end
  end

  // Barrier sequencer
  cras_esb_t state_q;
  logic      resolve;

  assign resolve = (state_q == ESB_RESOLVE);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ESB_IDLE;
    end else begin
      case (state_q)
        ESB_IDLE: begin
          if (esb_req) begin
            state_q <= ESB_DRAIN;
          end
        end
        ESB_DRAIN: begin
          // Only abort-capable accesses hold the barrier; no ordering or flush is done
          if (!async_abort_outstanding) begin
            state_q <= ESB_RESOLVE;
          end
        end
        ESB_RESOLVE: begin
          state_q <= ESB_DONE;
        end
        ESB_DONE: begin
          state_q <= ESB_IDLE;
        end
        default: begin
          state_q <= ESB_IDLE;
        end
      endcase
    end
  end

  // Pending system errors; a new set beats the barrier clear
  logic                   p_set;
  logic [`CRAS_SYN_W-1:0] psyn_q;

  assign p_set = sys_err_in || rsp_ue_q || abort_ue_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sei_pending_q <= 1'b0;
      psyn_q <= '0;
    end else if (p_set) begin
      sei_pending_q <= 1'b1;
      psyn_q <= sys_err_in ? sei_syndrome : `CRAS_SYN_INT;
    end else if (resolve) begin
      sei_pending_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vsei_pending_q <= 1'b0;
    end else if (vsei_set) begin
      vsei_pending_q <= 1'b1;
    end else if (resolve) begin
      vsei_pending_q <= 1'b0;
    end
  end

  logic p_defer;
  logic v_defer;

  assign p_defer = resolve && sei_pending_q && phys_masked;
  assign v_defer = resolve && vsei_pending_q && virt_masked;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      take_phys_q <= 1'b0;
      take_virt_q <= 1'b0;
      esb_done_q <= 1'b0;
    end else begin
      take_phys_q <= resolve && sei_pending_q && !phys_masked;
      take_virt_q <= resolve && vsei_pending_q && !virt_masked;
      esb_done_q <= (state_q == ESB_DONE);
    end
  end

  // Register port
  logic [3:0]             ea;
  logic                   acc_ok;
  logic [`CRAS_SYN_W-1:0] vsesr_q;
  logic [31:0]            disr_q;
  logic [31:0]            vdisr_q;
  logic [31:0]            ctrl_q;
  logic [31:0]            rd_v;

  always_comb begin
    ea = reg_addr;
    if (reg_addr == `CRAS_OFF_DISR && EL2_PRESENT && ctrl_q[`CRAS_CTRL_AMO] && reg_ns && reg_el == 2'd1) begin
      ea = `CRAS_OFF_VDISR;
    end
    if (reg_addr == `CRAS_OFF_DISR) begin
      acc_ok = (reg_el >= 2'd1);
    end else begin
      acc_ok = (reg_el >= 2'd2);
    end
    case (ea)
      `CRAS_OFF_DISR: rd_v = disr_q;
      `CRAS_OFF_VDISR: rd_v = vdisr_q;
      `CRAS_OFF_VSESR: rd_v = 32'(vsesr_q);
      `CRAS_OFF_CTRL: rd_v = ctrl_q;
      default: rd_v = '0;
    endcase
  end

  // Barrier recording takes priority over a software write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      disr_q <= `CRAS_RST_REG;
    end else if (p_defer) begin
      disr_q <= {1'b1, 7'h0, psyn_q};
    end else if (reg_wr && acc_ok && ea == `CRAS_OFF_DISR) begin
      disr_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vdisr_q <= `CRAS_RST_REG;
    end else if (v_defer) begin
      vdisr_q <= {1'b1, 7'h0, vsesr_q};
    end else if (reg_wr && acc_ok && ea == `CRAS_OFF_VDISR) begin
      vdisr_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vsesr_q <= '0;
      ctrl_q <= `CRAS_RST_REG;
    end else if (reg_wr && acc_ok) begin
      if (ea == `CRAS_OFF_VSESR) begin
        vsesr_q <= reg_wdata[`CRAS_SYN_W-1:0];
      end
      if (ea == `CRAS_OFF_CTRL) begin
        ctrl_q <= {31'h0, reg_wdata[`CRAS_CTRL_AMO]};
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_q <= '0;
    end else begin
      reg_rdata_q <= (reg_rd && acc_ok) ? rd_v : '0;
    end
  end

endmodule // cras_core

//--- core/cras_map.svh
`ifndef CRAS_MAP_SVH
`define CRAS_MAP_SVH
// Protected word widths
`define CRAS_L1T_W 34
`define CRAS_L1D_W 33
`define CRAS_TLB_W 71
`define CRAS_L2T_W256 35
`define CRAS_L2T_W512 34
`define CRAS_L2D_W 64
// Field positions inside a RAM word
`define CRAS_L1T_CHK 34
`define CRAS_L1D_POI 32
`define CRAS_L1D_CHK 33
`define CRAS_TLB_PAR 71
`define CRAS_L2T_CHK 35
`define CRAS_L2D_CHK 64
`define CRAS_L2D_POI 72
`define CRAS_WORD_W 73
// Register offsets and fields
`define CRAS_OFF_DISR 4'h0
`define CRAS_OFF_VDISR 4'h4
`define CRAS_OFF_VSESR 4'h8
`define CRAS_OFF_CTRL 4'hC
`define CRAS_CTRL_AMO 0
`define CRAS_DISR_A 31
`define CRAS_SYN_W 24
`define CRAS_SYN_INT 24'h00_0011
`define CRAS_RST_REG 32'h0000_0000
`endif

//--- core/cras_pkg.sv
package cras_pkg;
  typedef enum logic [2:0] {
    RAM_L1D_TAG, RAM_L1D_DATA, RAM_TLB,
    RAM_L2_TAG, RAM_L2_DATA, RAM_TQ
  } cras_ram_t;
  typedef enum logic [2:0] {
    ABT_LOAD, ABT_STORE, ABT_DCMAINT,
    ABT_ICMAINT, ABT_TLBI, ABT_COPYBACK
  } cras_abort_t;
  typedef enum logic [1:0] {
    ESB_IDLE, ESB_DRAIN, ESB_RESOLVE, ESB_DONE
  } cras_esb_t;
  typedef struct packed {
    logic [63:0] data;
    logic        ce;
    logic        ue;
  } cras_dec_t;
endpackage

//--- verification/cras_core_sva.sv
`timescale 1ns/1ps
module cras_sva_chk (
  // Clock and reset
  input wire logic                clk,
  input wire logic                arst_n,
  // RAM traffic
  input wire logic                wr_valid,
  input wire logic                ram_wr_en_q,
  input wire logic                rd_valid,
  input wire cras_pkg::cras_ram_t rd_ram,
  input wire logic                rsp_valid_q,
  input wire logic                rsp_poison_q,
  input wire logic                rsp_ce_q,
  input wire logic                rsp_de_q,
  input wire logic                rsp_ue_q,
  input wire logic                rsp_inval_q,
  input wire logic                rsp_evict_refill_q,
  input wire logic                rsp_walk_q,
  input wire logic                err_recovery_irq_q,
  // Aborts and barrier
  input wire logic                ext_abort_valid,
  input wire cras_pkg::cras_abort_t ext_abort_kind,
  input wire logic                abort_ue_q,
  input wire logic                async_abort_outstanding,
  input wire logic                phys_masked,
  input wire logic                virt_masked,
  input wire logic                take_phys_q,
  input wire logic                take_virt_q,
  input wire logic                esb_done_q
);
  import cras_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_wr_encode_next: assert property (ram_wr_en_q == $past(wr_valid))
    else $error("encoded word not one cycle after write");
  a_rd_check_next: assert property (rsp_valid_q == $past(rd_valid))
    else $error("read response not one cycle after read");
  a_ce_clean_class: assert property (rsp_ce_q |-> rsp_valid_q && !rsp_de_q && !rsp_ue_q)
    else $error("corrected error mixed with other class");
  a_de_data_ram: assert property (rsp_de_q |-> rsp_poison_q && $past(rd_ram) inside {RAM_L1D_DATA, RAM_L2_DATA})
    else $error("deferred error outside data RAM or without poison");
  a_ue_tag_ram: assert property (rsp_ue_q |-> rsp_inval_q && err_recovery_irq_q && !rsp_poison_q
    && $past(rd_ram) inside {RAM_L1D_TAG, RAM_L2_TAG}) else $error("tag uncorrected handling wrong");
  a_walk_tlb_only: assert property (rsp_walk_q |-> rsp_inval_q && !rsp_ce_q && $past(rd_ram) == RAM_TLB)
    else $error("table walk without translation parity error");
  a_evict_l1d_only: assert property (rsp_evict_refill_q |-> rsp_ce_q && $past(rd_ram) inside {RAM_L1D_TAG, RAM_L1D_DATA})
    else $error("evict and refill outside L1 data cache");
  a_abort_ue_kind: assert property (ext_abort_valid && ext_abort_kind != ABT_LOAD |=> abort_ue_q)
    else $error("external abort not reported uncorrected");
  a_take_then_done: assert property (take_phys_q || take_virt_q |=> esb_done_q)
    else $error("barrier did not complete right after take");
  a_masked_no_take: assert property (!(take_phys_q && phys_masked) && !(take_virt_q && virt_masked))
    else $error("masked interrupt was taken");
  a_drain_waits: assert property (esb_done_q |-> !$past(async_abort_outstanding, 3))
    else $error("barrier completed while aborts outstanding");

  c_corrected: cover property (rsp_ce_q);
  c_deferred: cover property (rsp_de_q);
  c_take_phys: cover property (take_phys_q);
  c_esb_done: cover property (esb_done_q);
endmodule // cras_sva_chk

bind cras_core cras_sva_chk u_cras_sva_chk (.*);

//--- verification/cras_ram_model.sv
`timescale 1ns/1ps
`include "cras_map.svh"
module cras_ram_model (
  // Clock
  input  wire logic                    clk,
  // Encoded words from the block
  input  wire logic                    ram_wr_en_q,
  input  wire cras_pkg::cras_ram_t     ram_wr_ram_q,
  input  wire logic [`CRAS_WORD_W-1:0] ram_wr_word_q,
  // Read command from the bench, with bit upsets to inject
  input  wire logic                    fetch,
  input  wire cras_pkg::cras_ram_t     fetch_ram,
  input  wire logic [`CRAS_WORD_W-1:0] flip,
  // Read side of the block
  output logic                         rd_valid,
  output cras_pkg::cras_ram_t          rd_ram,
  output logic [`CRAS_WORD_W-1:0]      rd_word
);
  import cras_pkg::*;
  logic [`CRAS_WORD_W-1:0] mem_q [8];
  logic [`CRAS_WORD_W-1:0] last_q;
  always_ff @(posedge clk) begin
    if (ram_wr_en_q) begin
      mem_q[ram_wr_ram_q] <= ram_wr_word_q;
    end
    if (fetch) begin
      last_q <= rd_word;
    end
  end
  // Idle bus shows the inverse of the last word, so a stale value never passes
  assign rd_valid = fetch;
  assign rd_ram   = fetch_ram;
  assign rd_word  = fetch ? (mem_q[fetch_ram] ^ flip) : ~last_q;
endmodule // cras_ram_model

//--- verification/tb_cache_ras_error_handling.sv
`timescale 1ns/1ps
`include "cras_map.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_cache_ras_error_handling;
  import cras_pkg::*;
  // Stimulus
  logic                    clk = 1'b0, arst_n = 1'b0, wr_valid = 1'b0, wr_poison = 1'b0, fetch = 1'b0;
  cras_ram_t               wr_ram = RAM_L1D_TAG, fetch_ram = RAM_L1D_TAG;
  logic [70:0]             wr_data = '0;
  logic [`CRAS_WORD_W-1:0] flip = '0;
  logic                    ext_abort_valid = 1'b0, esb_req = 1'b0, async_abort_outstanding = 1'b0;
  cras_abort_t             ext_abort_kind = ABT_LOAD;
  logic                    sys_err_in = 1'b0, vsei_set = 1'b0, phys_masked = 1'b0, virt_masked = 1'b0;
  logic [`CRAS_SYN_W-1:0]  sei_syndrome = '0;
  logic [3:0]              reg_addr = '0;
  logic [31:0]             reg_wdata = '0;
  logic                    reg_wr = 1'b0, reg_rd = 1'b0, reg_ns = 1'b0;
  logic [1:0]              reg_el = '0;
  // Observed
  logic                    rd_valid, ram_wr_en_q, rsp_valid_q, rsp_poison_q, rsp_ce_q, rsp_de_q, rsp_ue_q;
  logic                    rsp_inval_q, rsp_evict_refill_q, rsp_walk_q, err_recovery_irq_q, abort_ue_q;
  logic                    take_phys_q, take_virt_q, esb_done_q, sei_pending_q, vsei_pending_q;
  cras_ram_t               rd_ram, ram_wr_ram_q;
  logic [`CRAS_WORD_W-1:0] rd_word, ram_wr_word_q;
  logic [70:0]             rsp_data_q;
  logic [31:0]             reg_rdata_q;
  int                      error_cnt = 0, checked = 0;

  cras_core #(.L2_KB(256), .EL2_PRESENT(1'b1)) u_cras_core (.*);
  cras_ram_model u_cras_ram_model (.*);

  always #50 clk = ~clk;

  task automatic ram_write(input cras_ram_t r, input logic [70:0] d, input logic p);
    @(posedge clk);
    wr_valid  <= 1'b1;
    wr_ram    <= r;
    wr_data   <= d;
    wr_poison <= p;
    @(posedge clk);
    wr_valid  <= 1'b0;
    @(negedge clk);
  endtask

  task automatic ram_read(input cras_ram_t r, input logic [`CRAS_WORD_W-1:0] f);
    @(posedge clk);
    fetch     <= 1'b1;
    fetch_ram <= r;
    flip      <= f;
    @(posedge clk);
    fetch     <= 1'b0;
    @(negedge clk);
  endtask

  task automatic reg_op(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [1:0] el,
                        input logic ns);
    @(posedge clk);
    reg_wr    <= w;
    reg_rd    <= !w;
    reg_addr  <= a;
    reg_wdata <= d;
    reg_el    <= el;
    reg_ns    <= ns;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    @(negedge clk);
  endtask

  task automatic sei_pulse(input logic v, input logic [23:0] s);
    @(posedge clk);
    sys_err_in   <= !v;
    vsei_set     <= v;
    sei_syndrome <= s;
    @(posedge clk);
    sys_err_in   <= 1'b0;
    vsei_set     <= 1'b0;
    @(negedge clk);
  endtask

  task automatic esb_run(output logic tp, output logic tv, output int n);
    tp = 1'b0;
    tv = 1'b0;
    @(posedge clk);
    esb_req <= 1'b1;
    @(posedge clk);
    esb_req <= 1'b0;
    for (n = 0; n < 30; n++) begin
      @(negedge clk);
      if (take_phys_q === 1'b1) tp = 1'b1;
      if (take_virt_q === 1'b1) tv = 1'b1;
      if (esb_done_q === 1'b1) break;
    end
    `CHK("esb done", 1'b1, esb_done_q)
  endtask

  task automatic t_ecc();
    cras_ram_t   rl [5] = '{RAM_L1D_TAG, RAM_L1D_DATA, RAM_L2_TAG, RAM_L2_DATA, RAM_TQ};
    int          wl [5] = '{34, 32, 35, 64, 64};
    logic [4:0]  de_m = 5'h0A, ue_m = 5'h05, po_m = 5'h1A, ev_m = 5'h03;
    logic [70:0] d, m;
    for (int i = 0; i < 5; i++) begin
      m = (71'h1 << wl[i]) - 71'h1;
      d = 71'h55_A5A5_A5A5_A5A5_A5A5 & m;
      ram_write(rl[i], d, 1'b0);
      `CHK("stored payload", d, ram_wr_word_q[70:0] & m)
      ram_read(rl[i], '0);
      `CHK("clean data", d, rsp_data_q)
      `CHK("clean ce", 1'b0, rsp_ce_q)
      ram_read(rl[i], 73'h8);
      `CHK("fixed data", d, rsp_data_q)
      `CHK("single ce", 1'b1, rsp_ce_q)
      `CHK("evict refill", ev_m[i], rsp_evict_refill_q)
      ram_read(rl[i], 73'h28);
      `CHK("double ce", 1'b0, rsp_ce_q)
      `CHK("double de", de_m[i], rsp_de_q)
      `CHK("double ue", ue_m[i], rsp_ue_q)
      `CHK("double poison", po_m[i], rsp_poison_q)
      `CHK("double inval", ue_m[i], rsp_inval_q)
      `CHK("recovery irq", ue_m[i], err_recovery_irq_q)
    end
    $display("test ecc done");
  endtask

  task automatic t_tlb_poison();
    logic [70:0] d = 71'h4C_3A96_F00D_1234_5678;
    ram_write(RAM_TLB, d, 1'b0);
    `CHK("even parity", ^(d & 71'h55_5555_5555_5555_5555), ram_wr_word_q[71])
    `CHK("odd parity", ^(d & 71'h2A_AAAA_AAAA_AAAA_AAAA), ram_wr_word_q[72])
    ram_read(RAM_TLB, 73'h10);
    `CHK("entry inval", 1'b1, rsp_inval_q)
    `CHK("rewalk", 1'b1, rsp_walk_q)
    ram_write(RAM_L2_DATA, 71'h1234, 1'b1);
    `CHK("l2 poison bit", 1'b1, ram_wr_word_q[72])
    ram_read(RAM_L2_DATA, '0);
    `CHK("poison travels", 1'b1, rsp_poison_q)
    ram_write(RAM_L1D_DATA, 71'h5678, 1'b1);
    `CHK("l1 poison bit", 1'b1, ram_wr_word_q[32])
    ram_read(RAM_L1D_DATA, '0);
    `CHK("l1 poison read", 1'b1, rsp_poison_q)
    $display("test parity and poison done");
  endtask

  task automatic t_barrier();
    logic tp, tv;
    int   n;
    reg_op(1'b0, `CRAS_OFF_DISR, '0, 2'd1, 1'b0);
    `CHK("status reset", `CRAS_RST_REG, reg_rdata_q)
    sei_pulse(1'b0, 24'h12_3456);
    `CHK("pended", 1'b1, sei_pending_q)
    esb_run(tp, tv, n);
    `CHK("phys taken", 1'b1, tp)
    `CHK("quick barrier", 3, n)
    `CHK("pend cleared", 1'b0, sei_pending_q)
    phys_masked <= 1'b1;
    sei_pulse(1'b0, 24'hAB_CDEF);
    esb_run(tp, tv, n);
    `CHK("masked phys", 1'b0, tp)
    reg_op(1'b0, `CRAS_OFF_DISR, '0, 2'd1, 1'b0);
    `CHK("deferred status", 32'h80AB_CDEF, reg_rdata_q)
    reg_op(1'b0, `CRAS_OFF_DISR, '0, 2'd0, 1'b0);
    `CHK("status el0", 32'h0000_0000, reg_rdata_q)
    reg_op(1'b1, `CRAS_OFF_VSESR, 32'h0065_4321, 2'd2, 1'b0);
    sei_pulse(1'b1, 24'h00_0000);
    esb_run(tp, tv, n);
    `CHK("virt taken", 1'b1, tv)
    virt_masked <= 1'b1;
    sei_pulse(1'b1, 24'h00_0000);
    `CHK("virt pended", 1'b1, vsei_pending_q)
    esb_run(tp, tv, n);
    `CHK("masked virt", 1'b0, tv)
    `CHK("virt cleared", 1'b0, vsei_pending_q)
    reg_op(1'b0, `CRAS_OFF_VDISR, '0, 2'd2, 1'b0);
    `CHK("virt status", 32'h8065_4321, reg_rdata_q)
    reg_op(1'b1, `CRAS_OFF_CTRL, 32'h0000_0001, 2'd2, 1'b0);
    reg_op(1'b0, `CRAS_OFF_DISR, '0, 2'd1, 1'b1);
    `CHK("routed read", 32'h8065_4321, reg_rdata_q)
    reg_op(1'b0, `CRAS_OFF_DISR, '0, 2'd1, 1'b0);
    `CHK("secure read", 32'h80AB_CDEF, reg_rdata_q)
    reg_op(1'b0, 4'h2, '0, 2'd3, 1'b0);
    `CHK("unmapped read", 32'h0000_0000, reg_rdata_q)
    async_abort_outstanding <= 1'b1;
    fork
      esb_run(tp, tv, n);
      begin
        repeat (8) @(posedge clk);
        async_abort_outstanding <= 1'b0;
      end
    join
    `CHK("barrier waits", 1'b1, n > 6)
    $display("test barrier done");
  endtask

  task automatic t_abort();
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      ext_abort_valid <= 1'b1;
      ext_abort_kind  <= cras_abort_t'(k[2:0]);
      @(posedge clk);
      ext_abort_valid <= 1'b0;
      @(negedge clk);
      `CHK("abort ue", k != 0, abort_ue_q)
    end
    $display("test abort done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    $display("watchdog expired");
    report_and_stop();
  end

  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    t_ecc();
    t_tlb_poison();
    t_barrier();
    t_abort();
    report_and_stop();
  end
endmodule // tb_cache_ras_error_handling
